// ### pkg/guard_regs.svh
// command codes, setting slots, field positions and reset values of the write guard
`ifndef GUARD_REGS_SVH
`define GUARD_REGS_SVH
`define GD_CODE_PAGE     8'h00
`define GD_CODE_OPER     8'h01
`define GD_CODE_ONOFF    8'h02
`define GD_CODE_LOCK     8'h10
`define GD_CODE_STORE    8'h15
`define GD_CODE_RESTORE  8'h16
`define GD_CODE_PARAM0   8'h21
`define GD_N_SET         8
`define GD_IDX_LOCK      3'h0
`define GD_IDX_OPER      3'h1
`define GD_IDX_ONOFF     3'h2
`define GD_IDX_LAST      3'h7
`define GD_LOCK_ALL      8'h80
`define GD_LOCK_CTRL     8'h40
`define GD_LOCK_CFG      8'h20
`define GD_LOCK_NONE     8'h00
`define GD_SET_RESET     8'h00
`define GD_SB_CML        1
`define GD_CML_IVD       6
`define GD_CML_OTH       1
`endif

// ### pkg/guard_pkg.sv
// types shared by the write guard and its nonvolatile copier
package guard_pkg;
   typedef struct packed {
      logic       valid;
      logic       wr;
      logic [7:0] code;
      logic [7:0] data;
   } cmd_t;
   typedef struct packed {
      logic       req;
      logic       we;
      logic [2:0] addr;
      logic [7:0] wdata;
   } ee_req_t;
   typedef struct packed {
      logic       valid;
      logic       from_restore;
      logic [2:0] idx;
      logic [7:0] data;
   } load_t;
   typedef enum logic [1:0] {JOB_STORE, JOB_LOAD_ALL, JOB_LOAD_UNPROT} job_t;
   typedef enum logic [1:0] {CP_IDLE, CP_ISSUE, CP_WAIT} copier_state_t;
endpackage

// ### hw/nvm_copier.sv
// walks the setting slots in order, copying each to or from the nonvolatile store; a programming fault ends the walk early
`timescale 1ns/1ps
`include "guard_regs.svh"
module nvm_copier (
   input  wire logic                     clk_i,
   input  wire logic                     rst_b_i,
   input  wire logic                     start_i,
   input  wire guard_pkg::job_t          job_i,
   input  wire logic [7:0]               set_data_i,
   input  wire logic                     ee_ack_i,
   input  wire logic                     ee_err_i,
   input  wire logic [7:0]               ee_rdata_i,
   output logic                          busy_o,
   output logic                          fault_o,
   output logic [2:0]                    set_idx_o,
   output guard_pkg::ee_req_t            ee_o,
   output guard_pkg::load_t              load_o
);
   guard_pkg::copier_state_t state, next_state;
   guard_pkg::job_t          job, next_job;
   guard_pkg::ee_req_t       next_ee;
   guard_pkg::load_t         next_load;
   logic [2:0]               next_idx;
   logic                     next_busy, next_fault;

   // sequencer: one store request per slot, held until the store acknowledges
   always_comb begin
      next_state = state;
      next_job   = job;
      next_idx   = set_idx_o;
      next_busy  = busy_o;
      next_fault = 1'b0;
      next_ee    = ee_o;
      next_load  = '0;
      unique case (state)
         guard_pkg::CP_IDLE: begin
            if (start_i) begin
               next_job   = job_i;
               next_idx   = 3'h0;
               next_busy  = 1'b1;
               next_state = guard_pkg::CP_ISSUE;
            end
         end
         guard_pkg::CP_ISSUE: begin
            next_ee.req   = 1'b1;
            next_ee.we    = (job == guard_pkg::JOB_STORE);
            next_ee.addr  = set_idx_o;
            next_ee.wdata = set_data_i;
            next_state    = guard_pkg::CP_WAIT;
         end
         guard_pkg::CP_WAIT: begin
            if (ee_ack_i) begin
               next_ee.req = 1'b0;
               if (ee_err_i) begin
                  // a failed cell aborts the pass; later slots keep old contents
                  next_fault = 1'b1;
                  next_busy  = 1'b0;
                  next_state = guard_pkg::CP_IDLE;
               end else begin
                  if (!ee_o.we) begin
                     next_load.valid        = 1'b1;
                     next_load.from_restore = (job == guard_pkg::JOB_LOAD_UNPROT);
                     next_load.idx          = set_idx_o;
                     next_load.data         = ee_rdata_i;
                  end
                  if (set_idx_o == `GD_IDX_LAST) begin
                     next_busy  = 1'b0;
                     next_state = guard_pkg::CP_IDLE;
                  end else begin
                     next_idx   = set_idx_o + 3'h1;
                     next_state = guard_pkg::CP_ISSUE;
                  end
               end
            end
         end
         default: next_state = guard_pkg::CP_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state     <= guard_pkg::CP_IDLE;
         job       <= guard_pkg::JOB_STORE;
         set_idx_o <= 3'h0;
         busy_o    <= 1'b0;
         fault_o   <= 1'b0;
         ee_o      <= '0;
         load_o    <= '0;
      end else begin
         state     <= next_state;
         job       <= next_job;
         set_idx_o <= next_idx;
         busy_o    <= next_busy;
         fault_o   <= next_fault;
         ee_o      <= next_ee;
         load_o    <= next_load;
      end
   end

   a_store_first_slot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state == guard_pkg::CP_IDLE && start_i && job_i == guard_pkg::JOB_STORE)
      |-> ##2 (ee_o.req && ee_o.we && ee_o.addr == 3'h0))
      else $error("store pass did not begin with a write to slot zero");
   a_fault_aborts: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state == guard_pkg::CP_WAIT && ee_ack_i && ee_err_i) |=> (fault_o && !busy_o && !ee_o.req))
      else $error("programming fault did not end the pass");
endmodule // nvm_copier

// ### hw/write_guard_top.sv
// command write guard with lockout levels and store of settings to nonvolatile memory
`timescale 1ns/1ps
`include "guard_regs.svh"
module write_guard_top (
   input  wire logic                 CLK_I,
   input  wire logic                 RST_B_I,
   input  wire guard_pkg::cmd_t      CMD_I,
   input  wire logic                 CLEAR_I,
   input  wire logic                 EE_ACK_I,
   input  wire logic                 EE_ERR_I,
   input  wire logic [7:0]           EE_RDATA_I,
   output logic                      CMD_DONE_O,
   output logic                      CMD_REFUSED_O,
   output logic [7:0]                RD_DATA_O,
   output logic                      BUSY_O,
   output logic [7:0]                STATUS_BYTE_O,
   output logic [7:0]                STATUS_CML_O,
   output logic [7:0]                PAGE_O,
   output logic [7:0]                LOCK_O,
   output logic [7:0]                OPERATION_O,
   output logic [7:0]                ON_OFF_CONFIG_O,
   output guard_pkg::ee_req_t        EE_O
);
   logic [`GD_N_SET-1:0][7:0] settings, next_settings;
   logic [7:0]                page, next_page;
   logic                      next_done, next_refused;
   logic [7:0]                next_rd_data;
   logic [7:0]                next_status_byte, next_status_cml;
   logic                      boot, next_boot;
   logic                      start, next_start;
   guard_pkg::job_t           job, next_job;
   logic                      eng_busy, eng_fault;
   logic [2:0]                eng_idx;
   guard_pkg::load_t          load;
   logic [3:0]                hit_idx;
   logic                      cmd_busy;

   // code of the command that owns a setting slot
   function automatic logic [7:0] set_code(input logic [2:0] idx);
      logic [7:0] code;
      code = `GD_CODE_PARAM0 + {5'h0, idx} - 8'h03;
      if (idx == `GD_IDX_LOCK) code = `GD_CODE_LOCK;
      if (idx == `GD_IDX_OPER) code = `GD_CODE_OPER;
      if (idx == `GD_IDX_ONOFF) code = `GD_CODE_ONOFF;
      return code;
   endfunction

   // slot lookup: hit flag over the slot index
   function automatic logic [3:0] lookup(input logic [7:0] code);
      logic [3:0] res;
      res = 4'h0;
      for (int i = 0; i < `GD_N_SET; i++) begin
         if (set_code(3'(i)) == code) res = {1'b1, 3'(i)};
      end
      return res;
   endfunction

   // more than one of the three lock bits set
   function automatic logic multi_hot(input logic [7:0] d);
      return (d[7] & d[6]) | (d[7] & d[5]) | (d[6] & d[5]);
   endfunction

   // stored form of a lock byte: low bits dropped, invalid data unlocks
   function automatic logic [7:0] sanitize(input logic [7:0] d);
      return multi_hot(d) ? `GD_LOCK_NONE : {d[7:5], 5'h00};
   endfunction

   // whether a write to code passes the given lock byte
   function automatic logic write_ok(input logic [7:0] lock, input logic [7:0] code);
      logic ok;
      ok = 1'b1;
      unique case (lock)
         `GD_LOCK_ALL:  ok = (code == `GD_CODE_LOCK);
         `GD_LOCK_CTRL: ok = (code == `GD_CODE_LOCK) || (code == `GD_CODE_OPER)
                             || (code == `GD_CODE_PAGE);
         `GD_LOCK_CFG:  ok = (code == `GD_CODE_LOCK) || (code == `GD_CODE_OPER)
                             || (code == `GD_CODE_PAGE) || (code == `GD_CODE_ONOFF);
         default:       ok = 1'b1;
      endcase
      return ok;
   endfunction

   assign hit_idx  = lookup(CMD_I.code);
   // the engine owns the slots until its last load lands, so commands are turned away
   assign cmd_busy = boot || start || eng_busy || load.valid;

   // command decode, reload writes and status flags
   always_comb begin
      next_settings    = settings;
      next_page        = page;
      next_done        = 1'b0;
      next_refused     = 1'b0;
      next_rd_data     = RD_DATA_O;
      next_boot        = 1'b0;
      next_start       = 1'b0;
      next_job         = job;
      next_status_cml  = STATUS_CML_O;
      if (boot) begin
         // power-on reload takes every slot, protection does not apply
         next_start = 1'b1;
         next_job   = guard_pkg::JOB_LOAD_ALL;
      end
      if (CLEAR_I) begin
         next_status_cml[`GD_CML_IVD] = 1'b0;
         next_status_cml[`GD_CML_OTH] = 1'b0;
      end
      if (CMD_I.valid) begin
         if (cmd_busy) begin
            next_refused = 1'b1;
         end else if (!CMD_I.wr) begin
            // reads never consult the lock byte
            if (hit_idx[3]) begin
               next_done    = 1'b1;
               next_rd_data = settings[hit_idx[2:0]];
            end else if (CMD_I.code == `GD_CODE_PAGE) begin
               next_done    = 1'b1;
               next_rd_data = page;
            end else begin
               next_refused = 1'b1;
            end
         end else if (CMD_I.code == `GD_CODE_STORE) begin
            next_start = 1'b1;
            next_job   = guard_pkg::JOB_STORE;
            next_done  = 1'b1;
         end else if (CMD_I.code == `GD_CODE_RESTORE) begin
            next_start = 1'b1;
            next_job   = guard_pkg::JOB_LOAD_UNPROT;
            next_done  = 1'b1;
         end else if (!write_ok(settings[`GD_IDX_LOCK], CMD_I.code)) begin
            next_refused = 1'b1;
         end else if (CMD_I.code == `GD_CODE_LOCK) begin
            next_settings[`GD_IDX_LOCK] = sanitize(CMD_I.data);
            next_done = 1'b1;
            if (multi_hot(CMD_I.data)) next_status_cml[`GD_CML_IVD] = 1'b1;
         end else if (hit_idx[3]) begin
            next_settings[hit_idx[2:0]] = CMD_I.data;
            next_done = 1'b1;
         end else if (CMD_I.code == `GD_CODE_PAGE) begin
            next_page = CMD_I.data;
            next_done = 1'b1;
         end else begin
            next_refused = 1'b1;
         end
      end
      // restore leaves protected slots alone; reload overwrites everything
      if (load.valid && (!load.from_restore || write_ok(settings[`GD_IDX_LOCK], set_code(load.idx)))) begin
         next_settings[load.idx] = (load.idx == `GD_IDX_LOCK) ? sanitize(load.data) : load.data;
      end
      if (eng_fault) next_status_cml[`GD_CML_OTH] = 1'b1;
      // summary bit follows the flags so a clear and a new fault never race
      next_status_byte = 8'h00;
      next_status_byte[`GD_SB_CML] = next_status_cml[`GD_CML_IVD] | next_status_cml[`GD_CML_OTH];
   end

   // guard registers
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         settings      <= {`GD_N_SET{`GD_SET_RESET}};
         page          <= 8'h00;
         CMD_DONE_O    <= 1'b0;
         CMD_REFUSED_O <= 1'b0;
         RD_DATA_O     <= 8'h00;
         STATUS_BYTE_O <= 8'h00;
         STATUS_CML_O  <= 8'h00;
         boot          <= 1'b1;
         start         <= 1'b0;
         job           <= guard_pkg::JOB_LOAD_ALL;
      end else begin
         settings      <= next_settings;
         page          <= next_page;
         CMD_DONE_O    <= next_done;
         CMD_REFUSED_O <= next_refused;
         RD_DATA_O     <= next_rd_data;
         STATUS_BYTE_O <= next_status_byte;
         STATUS_CML_O  <= next_status_cml;
         boot          <= next_boot;
         start         <= next_start;
         job           <= next_job;
      end
   end

   // live settings straight from the slot flops and the page register
   assign PAGE_O          = page;
   assign LOCK_O          = settings[`GD_IDX_LOCK];
   assign OPERATION_O     = settings[`GD_IDX_OPER];
   assign ON_OFF_CONFIG_O = settings[`GD_IDX_ONOFF];

   nvm_copier u_copier (
      .clk_i      (CLK_I),
      .rst_b_i    (RST_B_I),
      .start_i    (start),
      .job_i      (job),
      .set_data_i (settings[eng_idx]),
      .ee_ack_i   (EE_ACK_I),
      .ee_err_i   (EE_ERR_I),
      .ee_rdata_i (EE_RDATA_I),
      .busy_o     (BUSY_O),
      .fault_o    (eng_fault),
      .set_idx_o  (eng_idx),
      .ee_o       (EE_O),
      .load_o     (load)
   );
   assign eng_busy = BUSY_O;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);

   a_full_lock_refuse: assert property (
      (CMD_I.valid && CMD_I.wr && !cmd_busy && settings[0] == `GD_LOCK_ALL && CMD_I.code != `GD_CODE_LOCK
       && CMD_I.code != `GD_CODE_STORE && CMD_I.code != `GD_CODE_RESTORE) |=> (CMD_REFUSED_O && !CMD_DONE_O))
      else $error("write passed the full lock");
   a_ctrl_lock_pass: assert property (
      (CMD_I.valid && CMD_I.wr && !cmd_busy && settings[0] == `GD_LOCK_CTRL && CMD_I.code == `GD_CODE_OPER)
      |=> (CMD_DONE_O && OPERATION_O == $past(CMD_I.data)))
      else $error("operation write refused under control lock");
   a_cfg_lock_block: assert property (
      (CMD_I.valid && CMD_I.wr && !cmd_busy && settings[0] == `GD_LOCK_CFG && hit_idx[3]
       && hit_idx[2:0] > `GD_IDX_ONOFF) |=> CMD_REFUSED_O)
      else $error("parameter write passed the config lock");
   a_lock_low_zero: assert property (LOCK_O[4:0] == 5'h00)
      else $error("low lock bits not zero");
   a_invalid_unlocks: assert property (
      (CMD_I.valid && CMD_I.wr && !cmd_busy && CMD_I.code == `GD_CODE_LOCK && multi_hot(CMD_I.data))
      |=> (LOCK_O == `GD_LOCK_NONE))
      else $error("invalid lock data left protection on");
   a_invalid_flags: assert property (
      (CMD_I.valid && CMD_I.wr && !cmd_busy && CMD_I.code == `GD_CODE_LOCK && multi_hot(CMD_I.data))
      |=> (STATUS_CML_O[`GD_CML_IVD] && STATUS_BYTE_O[`GD_SB_CML]))
      else $error("invalid lock data did not raise flags");
   a_store_while_on: assert property (
      (CMD_I.valid && CMD_I.wr && !cmd_busy && CMD_I.code == `GD_CODE_STORE) |=> ##1 BUSY_O [*2])
      else $error("store command did not start a copy");
   a_fault_flags: assert property (
      eng_fault |=> (STATUS_CML_O[`GD_CML_OTH] && STATUS_BYTE_O[`GD_SB_CML]))
      else $error("programming fault did not raise flags");
   a_read_open: assert property (
      (CMD_I.valid && !CMD_I.wr && !cmd_busy && hit_idx[3]) |=> (CMD_DONE_O && RD_DATA_O == $past(settings[hit_idx[2:0]])))
      else $error("read refused or wrong data");
   a_restore_guard: assert property (
      (load.valid && load.from_restore && !write_ok(settings[0], set_code(load.idx))) |=> $stable(settings))
      else $error("restore overwrote a protected setting");
   a_blocked_kept: assert property (
      (CMD_I.valid && CMD_I.wr && !cmd_busy && !write_ok(settings[0], CMD_I.code)
       && CMD_I.code != `GD_CODE_STORE && CMD_I.code != `GD_CODE_RESTORE) |=> ($stable(settings) && $stable(page)))
      else $error("blocked write changed a setting");
endmodule // write_guard_top

// ### test/ee_model.sv
// behavioural nonvolatile store that answers the copier's requests
`timescale 1ns/1ps
module ee_model (
   input  wire logic               clk_i,
   input  wire logic               rst_b_i,
   input  wire guard_pkg::ee_req_t ee_i,
   input  wire logic [3:0]         delay_i,
   input  wire logic               fail_en_i,
   input  wire logic [2:0]         fail_addr_i,
   output logic                    ack_o,
   output logic                    err_o,
   output logic [7:0]              rdata_o
);
   logic [7:0] mem [8];
   logic [3:0] wait_cnt;
   logic       fail;

   // cells keep their contents across reset, as real ones do
   initial begin
      mem = '{8'h40, 8'h00, 8'h13, 8'h5a, 8'h66, 8'h71, 8'h8c, 8'h9e};
      rdata_o = 8'h00;
   end

   assign fail = fail_en_i && (ee_i.addr == fail_addr_i);

   // one ack per request after a chosen wait; a failing cell keeps its old value
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         wait_cnt <= 4'h0;
      end else begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         rdata_o <= ~rdata_o; // read data is inverted every cycle outside an answer
         if (ee_i.req && !ack_o) begin
            if (wait_cnt >= delay_i) begin
               wait_cnt <= 4'h0;
               ack_o <= 1'b1;
               err_o <= fail;
               rdata_o <= mem[ee_i.addr];
               if (ee_i.we && !fail) begin
                  mem[ee_i.addr] <= ee_i.wdata;
               end
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
      end
   end
endmodule // ee_model

// ### test/test_pmbus_write_guard_and_nvm_store.sv
// self-checking bench for the command write guard and the settings store
`timescale 1ns/1ps
`include "guard_regs.svh"
module test_pmbus_write_guard_and_nvm_store;
   logic               clk = 1'b0;
   logic               rst_b = 1'b0;
   logic               clear = 1'b0;
   logic               fail_en = 1'b0;
   guard_pkg::cmd_t    cmd = '0;
   guard_pkg::ee_req_t ee;
   logic               ee_ack, ee_err, done, refused, busy;
   logic [7:0]         ee_rdata, rd_data, st_byte, st_cml, page, lock, oper, onoff;
   logic [3:0]         delay = 4'h0;
   logic [2:0]         fail_addr = 3'h0;
   int                 bad_count = 0, compares = 0, cycles = 0, exp_addr = 0;
   int                 exp_page, exp_ivd, exp_oth, i, j;
   int                 exp_set[8];
   int                 ee_mem[8] = '{'h40, 'h00, 'h13, 'h5a, 'h66, 'h71, 'h8c, 'h9e};
   int                 codes[6] = '{0, 1, 2, 'h21, 'h25, 'h30};
   int                 levels[4] = '{'h80, 'h40, 'h20, 'h00};
   int                 bad_lock[4] = '{'he0, 'hc0, 'ha0, 'h60};
   bit                 copying = 1'b0;

   always #12.5 clk = ~clk;

   write_guard_top u_dut (.CLK_I(clk), .RST_B_I(rst_b), .CMD_I(cmd), .CLEAR_I(clear), .EE_ACK_I(ee_ack),
      .EE_ERR_I(ee_err), .EE_RDATA_I(ee_rdata), .CMD_DONE_O(done), .CMD_REFUSED_O(refused),
      .RD_DATA_O(rd_data), .BUSY_O(busy), .STATUS_BYTE_O(st_byte), .STATUS_CML_O(st_cml),
      .PAGE_O(page), .LOCK_O(lock), .OPERATION_O(oper), .ON_OFF_CONFIG_O(onoff), .EE_O(ee));

   ee_model u_ee (.clk_i(clk), .rst_b_i(rst_b), .ee_i(ee), .delay_i(delay), .fail_en_i(fail_en),
      .fail_addr_i(fail_addr), .ack_o(ee_ack), .err_o(ee_err), .rdata_o(ee_rdata));

   task automatic check(input logic [7:0] seen, input int exp, input string what);
      compares++;
      if (seen !== exp[7:0]) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp[7:0]);
      end
   endtask

   function automatic int code_of(input int s);
      return s == 0 ? `GD_CODE_LOCK : (s < 3 ? s : 'h1e + s);
   endfunction

   function automatic int slot_of(input int c);
      for (int s = 0; s < 8; s++) if (code_of(s) == c) return s;
      return -1;
   endfunction

   // write permission of the model at the current lock level
   function automatic bit allowed(input int c);
      if (c == 'h10 || c == 'h15 || c == 'h16 || exp_set[0] == 0) return 1'b1;
      if (exp_set[0] == 'h20) return c <= 2;
      return exp_set[0] == 'h40 && c <= 1;
   endfunction

   task automatic check_state;
      check(page, exp_page, "page");
      check(lock, exp_set[0], "lock byte");
      check(oper, exp_set[1], "operation");
      check(onoff, exp_set[2], "on off config");
      check(st_cml, exp_ivd * 'h40 + exp_oth * 2, "cml status");
      check(st_byte, (exp_ivd | exp_oth) * 2, "status byte");
   endtask

   // one command, predicted by the model, then answer and state compared
   task automatic send(input bit wr, input int code, input int data);
      bit ok;
      int s;
      s = slot_of(code);
      ok = (code == 0 || s >= 0 || (wr && code inside {'h15, 'h16})) && (!wr || allowed(code)) && !copying;
      @(posedge clk);
      cmd <= '{1'b1, wr, code[7:0], data[7:0]};
      @(posedge clk);
      cmd.valid <= 1'b0;
      if (ok && wr && code == 0) exp_page = data;
      else if (ok && wr && s == 0) begin
         exp_ivd = (data[7] + data[6] + data[5] > 1) ? 1 : exp_ivd;
         exp_set[0] = (data[7] + data[6] + data[5] > 1) ? 0 : data & 'he0;
      end else if (ok && wr && s > 0) exp_set[s] = data;
      @(negedge clk);
      check(done, ok, "accepted");
      check(refused, !ok, "refused");
      if (ok && !wr) check(rd_data, code == 0 ? exp_page : exp_set[s], "read data");
      check_state;
   endtask

   task automatic wait_busy;
      for (int n = 0; n < 600 && busy !== 1'b1; n++) @(negedge clk);
      for (int n = 0; n < 600 && busy !== 1'b0; n++) @(negedge clk);
      check(busy, 0, "copy finished");
      repeat (2) @(negedge clk);
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      exp_set = ee_mem;
      exp_page = 0;
      exp_ivd = 0;
      exp_oth = 0;
      wait_busy;
      check_state;
   endtask

   // store all settings, optionally with a programming fault at one address
   task automatic store(input bit fail, input int at);
      fail_en <= fail;
      fail_addr <= at[2:0];
      delay <= 4'($urandom_range(0, 15));
      exp_addr = 0;
      send(1'b1, `GD_CODE_STORE, 0);
      copying = 1'b1;
      send(1'b1, 1, $urandom); // a command during the copy is turned away
      wait_busy;
      copying = 1'b0;
      fail_en <= 1'b0;
      for (int k = 0; k < 8 && !(fail && k >= at); k++) ee_mem[k] = exp_set[k];
      exp_oth = fail ? 1 : exp_oth;
      check_state;
   endtask

   task automatic clr;
      @(posedge clk);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      exp_ivd = 0;
      exp_oth = 0;
      @(negedge clk);
      check_state;
   endtask

   task automatic read_all(input string name);
      for (int k = 0; k < 8; k++) send(1'b0, code_of(k), 0);
      $display("test %s done", name);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // every stored byte leaves in ascending address order with the live setting
   always @(posedge clk) begin
      if (ee_ack && ee.req && ee.we) begin
         check(ee.addr, exp_addr, "store order");
         check(ee.wdata, exp_set[exp_addr % 8], "store data");
         exp_addr++;
      end
   end

   // hang guard, far above the fewer than a thousand cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         finish_test;
      end
   end

   initial begin
      void'($urandom(32'h8f35e3e1));
      do_reset;
      read_all("boot reload");
      for (i = 0; i < 4; i++) begin
         send(1'b1, `GD_CODE_LOCK, levels[i] | ($urandom & 'h1f));
         for (j = 0; j < 6; j++) begin
            send(1'b1, codes[j], $urandom);
            send(1'b0, codes[j], 0);
         end
      end
      $display("test lock levels done");
      for (i = 0; i < 4; i++) begin
         send(1'b1, `GD_CODE_LOCK, `GD_LOCK_ALL);
         send(1'b1, `GD_CODE_LOCK, bad_lock[i] | ($urandom & 'h1f));
         send(1'b1, 'h21, $urandom);
      end
      clr;
      $display("test invalid lock done");
      send(1'b1, 1, 'h80); // output left running through the store
      send(1'b1, `GD_CODE_LOCK, `GD_LOCK_ALL);
      store(1'b0, 0);
      do_reset;
      read_all("store and reload");
      send(1'b1, `GD_CODE_LOCK, `GD_LOCK_CFG);
      send(1'b1, 1, $urandom);
      send(1'b1, 2, $urandom);
      store(1'b1, 3);
      clr;
      send(1'b1, `GD_CODE_LOCK, `GD_LOCK_NONE);
      send(1'b1, 'h21, $urandom);
      send(1'b1, `GD_CODE_LOCK, `GD_LOCK_CFG);
      send(1'b1, 1, $urandom);
      send(1'b1, 2, $urandom);
      send(1'b1, `GD_CODE_RESTORE, 0);
      copying = 1'b1;
      wait_busy;
      copying = 1'b0;
      for (i = 0; i < 3; i++) exp_set[i] = ee_mem[i]; // only unprotected slots take stored values
      check_state;
      read_all("restore and fault");
      finish_test;
   end
endmodule // test_pmbus_write_guard_and_nvm_store
